//--- hdl/ubrg_baud_gen.sv
`timescale 1ns/1ns
`default_nettype none
module ubrg_baud_gen (
    input wire logic core_clk, // peripheral clock
    input wire logic reset_n, // asynchronous reset, low
    input wire ubrg_pkg::ubrg_bg_cfg_t cfg, // generator settings
    output logic tick, // pulse per timer underflow, none if a pulse went out the clock before
    output logic ndov // normal divider overflow pulse
);
    typedef struct packed {
        logic [6:0] pre;
        logic [7:0] acc;
        logic [7:0] tmr;
        logic tick;
        logic ndov;
    } ubrg_bg_t;
    ubrg_bg_t r;
    ubrg_bg_t n;
    logic [6:0] mask;
    logic f_div;
    logic [8:0] sum;
    logic nd_mode;
    logic clk_in;
    logic run;

    // divider chain and timer gating
    assign mask = ~(ubrg_pkg::PRE_ALL << cfg.pre_sel);
    assign f_div = &(r.pre | ~mask);
    assign sum = {1'b0, r.acc} + {1'b0, cfg.step};
    assign nd_mode = cfg.fd_en & cfg.fd_mode;
    assign clk_in = cfg.fd_en ? (f_div & sum[8]) : f_div;
    assign run = cfg.run & ~nd_mode;

    // prescaler, divider and count-down reload timer
    always_comb begin
        n = r;
        n.pre = r.pre + 7'h01;
        n.tick = 1'b0;
        n.ndov = 1'b0;
        if (cfg.fd_en && f_div) begin
            if (nd_mode) begin
                n.ndov = r.acc == ubrg_pkg::CNT_TOP;
                n.acc = n.ndov ? cfg.step : r.acc + 8'h01;
            end else begin
                n.acc = sum[7:0];
            end
        end
        if (run && clk_in) begin
            if (r.tmr == ubrg_pkg::RST_BYTE) begin
                n.tmr = cfg.reload;
                n.tick = ~r.tick;
            end else begin
                n.tmr = r.tmr - 8'h01;
            end
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tick = r.tick;
    assign ndov = r.ndov;

    default clocking bg_cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    AST_TICK_SPACED: assert property (tick |=> !tick)
        else $error("serial ticks closer than two clocks");
    AST_RELOAD: assert property (
        run && clk_in && r.tmr == 8'h00 |=> r.tmr == $past(cfg.reload))
        else $error("timer did not reload on underflow");
    AST_ND_STOP: assert property (
        nd_mode ##1 nd_mode |-> !tick)
        else $error("baud tick in normal divider mode");
    AST_ND_OVF: assert property (
        nd_mode && f_div && r.acc == 8'hFF |=> ndov && r.acc == $past(cfg.step))
        else $error("normal divider overflow wrong");
endmodule // ubrg_baud_gen
`default_nettype wire

//--- hdl/ubrg_pkg.sv
`default_nettype none
package ubrg_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [3:0] A_CTRL = 4'h0; // mode and receive control
    localparam logic [3:0] A_STAT = 4'h1; // event flags, write 1 clears
    localparam logic [3:0] A_TXBUF = 4'h2; // write starts a frame
    localparam logic [3:0] A_RXBUF = 4'h3; // last received byte
    localparam logic [3:0] A_BAUD = 4'h4; // baud_ctrl_reg
    localparam logic [3:0] A_FDIV = 4'h5; // frac_div_ctrl_reg
    localparam logic [3:0] A_STEP = 4'h6; // frac_increment_reg
    localparam logic [3:0] A_RELOAD = 4'h7; // baud_reload_reg
    localparam logic [3:0] A_T1RLD = 4'h8; // timer1_high_byte
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int C_MODE = 0; // two bits
    localparam int C_RXEN = 2;
    localparam int C_DBL = 3; // baud_double_sel
    localparam int C_T1 = 4; // timer 1 as rate source
    localparam int C_TB9 = 5; // ninth transmit bit
    localparam int C_MP = 6; // multiprocessor filter
    localparam int S_TXD = 0;
    localparam int S_RXD = 1;
    localparam int S_RB9 = 2;
    localparam int S_OVR = 3;
    localparam int S_NDOV = 4;
    localparam int B_RUN = 0; // baud_timer_run
    localparam int B_PRE = 1; // baud_prescale_sel, three bits
    localparam int F_EN = 0; // frac_div_enable
    localparam int F_MODE = 1; // frac_div_mode_select
    localparam logic [1:0] MODE0 = 2'h0;
    localparam logic [1:0] MODE2 = 2'h2;
    // ----------------------------------------
    // counts and reset values
    // ----------------------------------------
    localparam logic [3:0] OVS_LAST = 4'hF; // sixteen ticks per bit
    localparam logic [3:0] OVS_MID = 4'h7; // mid-bit sample point
    localparam logic [3:0] M0_LAST = 4'h1; // two clocks per bit
    localparam logic [3:0] LAST_M0 = 4'h7;
    localparam logic [3:0] LAST_8 = 4'h9;
    localparam logic [3:0] LAST_9 = 4'hA;
    localparam logic [1:0] M2_FAST = 2'h1; // clk/32 bit rate
    localparam logic [1:0] M2_SLOW = 2'h3; // clk/64 bit rate
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] CNT_TOP = 8'hFF;
    localparam logic [6:0] PRE_ALL = 7'h7F;
    localparam logic LINE_IDLE = 1'b1;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } ubrg_bus_t;

    typedef struct packed {
        logic run;
        logic [2:0] pre_sel;
        logic fd_en;
        logic fd_mode;
        logic [7:0] step;
        logic [7:0] reload;
    } ubrg_bg_cfg_t;
endpackage
`default_nettype wire

//--- hdl/ubrg_timer1.sv
`timescale 1ns/1ns
`default_nettype none
module ubrg_timer1 (
    input wire logic core_clk, // peripheral clock
    input wire logic reset_n, // asynchronous reset, low
    input wire logic run, // count enable
    input wire logic [7:0] reload, // timer1_high_byte
    output logic ovf // one pulse per overflow
);
    typedef struct packed {
        logic half;
        logic [7:0] cnt;
        logic ovf;
    } ubrg_t1_t;
    ubrg_t1_t r;
    ubrg_t1_t n;

    // up count every second clock, auto reload at overflow
    always_comb begin
        n = r;
        n.ovf = 1'b0;
        if (run) begin
            n.half = ~r.half;
            if (r.half) begin
                if (r.cnt == ubrg_pkg::CNT_TOP) begin
                    n.cnt = reload;
                    n.ovf = 1'b1;
                end else begin
                    n.cnt = r.cnt + 8'h01;
                end
            end
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign ovf = r.ovf;
endmodule // ubrg_timer1
`default_nettype wire

//--- hdl/ubrg_uart.sv
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - transmit and receive concurrently; receive buffered (mode 0 shares one shift engine, one direction at a time)
// - unread byte at next completion: one lost
// - 8 or 9 data bits, LSB first
// - mode 0: 8-bit shift register at clk/2
// - mode 2: 9-bit frames at clk/32 or clk/64
// - modes 1, 3: generator or timer 1 rate
// - timer clocked by divider output or prescaler
// - run bit gates timer outside normal divider mode, where it has no effect
// - underflow reloads timer, emits a serial pulse unless one went out the clock before
// - normal divider mode stops the baud timer
// - prescaler divides clock by two to sel
// - fractional divider scales rate by increment/256
// - rate is clk/(16*prescale*(reload+1)), but clk/32 with prescale 1 and reload 0
// - baud rate never exceeds clk/32 outside mode 0
// - request raised on transmit and receive completion
// - timer 1 rate from double sel and reload
// - normal mode counts up, overflow flag, request
module ubrg_uart (
    input wire logic core_clk, // peripheral clock
    input wire logic reset_n, // asynchronous reset, low
    input wire ubrg_pkg::ubrg_bus_t bus, // register strobes and data
    output logic [7:0] rdata, // read data, cycle after strobe
    output logic txd, // serial out, mode 0 shift clock
    input wire logic rxd_in, // serial in, mode 0 data in
    output logic rxd_out, // mode 0 data out
    output logic rxd_oe, // mode 0 data drive enable
    output logic irq_req // pending frame or divider event
);
    typedef enum logic [1:0] {SH_IDLE, SH_TX, SH_M0RX} ubrg_sh_t;
    typedef enum logic {RX_IDLE, RX_RUN} ubrg_rx_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [4:0] stat;
        logic [3:0] bctrl;
        logic [1:0] fdctrl;
        logic [7:0] step;
        logic [7:0] reload;
        logic [7:0] t1rld;
        logic [7:0] rxdata;
        logic [7:0] rdata;
        logic irq;
        ubrg_sh_t sh_st;
        logic [10:0] sh;
        logic [3:0] sh_bit;
        logic [3:0] sh_sub;
        logic txd;
        logic rxd_out;
        logic rxd_oe;
        ubrg_rx_t rx_st;
        logic [9:0] rx_sh;
        logic [3:0] rx_bit;
        logic [3:0] rx_sub;
        logic [1:0] m2cnt;
        logic t1half;
    } ubrg_st_t;

    ubrg_st_t r;
    ubrg_st_t n;
    ubrg_pkg::ubrg_bg_cfg_t bg_cfg;
    logic [1:0] mode;
    logic nine;
    logic m0;
    logic bg_tick;
    logic ndov;
    logic t1_ovf;
    logic t1_tick;
    logic m2_tick;
    logic tick;
    logic tx_go;
    logic [4:0] clr;
    logic [3:0] sh_last;
    logic [3:0] rx_last;
    logic [9:0] rx_nsh;
    logic [7:0] rx_byte;
    logic rx_b9;
    logic rx_keep;

    // ----------------------------------------
    // rate sources
    // ----------------------------------------

    // generator settings from the software registers
    assign bg_cfg.run = r.bctrl[ubrg_pkg::B_RUN];
    assign bg_cfg.pre_sel = r.bctrl[ubrg_pkg::B_PRE +: 3];
    assign bg_cfg.fd_en = r.fdctrl[ubrg_pkg::F_EN];
    assign bg_cfg.fd_mode = r.fdctrl[ubrg_pkg::F_MODE];
    assign bg_cfg.step = r.step;
    assign bg_cfg.reload = r.reload;

    ubrg_baud_gen u_bg (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .cfg(bg_cfg),
        .tick(bg_tick),
        .ndov(ndov)
    );

    ubrg_timer1 u_t1 (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .run(r.ctrl[ubrg_pkg::C_T1]),
        .reload(r.t1rld),
        .ovf(t1_ovf)
    );

    // oversampling tick per mode
    assign mode = r.ctrl[ubrg_pkg::C_MODE +: 2];
    assign nine = mode[1];
    assign m0 = mode == ubrg_pkg::MODE0;
    assign m2_tick = r.m2cnt == (r.ctrl[ubrg_pkg::C_DBL] ?
        ubrg_pkg::M2_FAST : ubrg_pkg::M2_SLOW);
    assign t1_tick = t1_ovf & (r.ctrl[ubrg_pkg::C_DBL] | r.t1half);
    assign tick = (mode == ubrg_pkg::MODE2) ? m2_tick :
        (r.ctrl[ubrg_pkg::C_T1] ? t1_tick : bg_tick);

    // ----------------------------------------
    // frame decode helpers
    // ----------------------------------------

    // transmit start, flag clear and frame lengths
    assign tx_go = bus.wr && bus.addr == ubrg_pkg::A_TXBUF &&
        r.sh_st == SH_IDLE;
    assign clr = (bus.wr && bus.addr == ubrg_pkg::A_STAT) ?
        bus.wdata[4:0] : 5'h00;
    assign sh_last = m0 ? ubrg_pkg::LAST_M0 :
        (nine ? ubrg_pkg::LAST_9 : ubrg_pkg::LAST_8);
    assign rx_last = nine ? ubrg_pkg::LAST_9 : ubrg_pkg::LAST_8;

    // receive shift with the sample entering at the top, LSB first
    assign rx_nsh = {rxd_in, r.rx_sh[9:1]};
    assign rx_byte = nine ? rx_nsh[7:0] : rx_nsh[8:1];
    assign rx_b9 = nine ? rx_nsh[8] : rx_nsh[9];
    assign rx_keep = rxd_in &
        ~(r.ctrl[ubrg_pkg::C_MP] & nine & ~rx_nsh[8]);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        n = r;
        n.rdata = ubrg_pkg::RST_BYTE;
        n.stat = r.stat & ~clr;
        n.m2cnt = m2_tick ? 2'h0 : r.m2cnt + 2'h1;
        n.t1half = r.t1half ^ t1_ovf;
        // register writes
        if (bus.wr) begin
            case (bus.addr)
                ubrg_pkg::A_CTRL: n.ctrl = bus.wdata;
                ubrg_pkg::A_BAUD: n.bctrl = bus.wdata[3:0];
                ubrg_pkg::A_FDIV: n.fdctrl = bus.wdata[1:0];
                ubrg_pkg::A_STEP: n.step = bus.wdata;
                ubrg_pkg::A_RELOAD: n.reload = bus.wdata;
                ubrg_pkg::A_T1RLD: n.t1rld = bus.wdata;
                default: ;
            endcase
        end
        // register reads, answered in the next cycle only
        if (bus.rd) begin
            case (bus.addr)
                ubrg_pkg::A_CTRL: n.rdata = r.ctrl;
                ubrg_pkg::A_STAT: n.rdata = {3'h0, r.stat};
                ubrg_pkg::A_TXBUF: n.rdata = {7'h00, r.sh_st != SH_IDLE};
                ubrg_pkg::A_RXBUF: n.rdata = r.rxdata;
                ubrg_pkg::A_BAUD: n.rdata = {4'h0, r.bctrl};
                ubrg_pkg::A_FDIV: n.rdata = {6'h00, r.fdctrl};
                ubrg_pkg::A_STEP: n.rdata = r.step;
                ubrg_pkg::A_RELOAD: n.rdata = r.reload;
                ubrg_pkg::A_T1RLD: n.rdata = r.t1rld;
                default: n.rdata = ubrg_pkg::RST_BYTE;
            endcase
        end
        // shift engine: async transmit, mode 0 transmit and receive
        unique case (r.sh_st)
            SH_IDLE: begin
                n.sh_sub = 4'h0;
                n.sh_bit = 4'h0;
                if (tx_go) begin
                    n.sh_st = SH_TX;
                    n.sh = m0 ? {3'h7, bus.wdata} :
                        {1'b1, ~nine | r.ctrl[ubrg_pkg::C_TB9],
                         bus.wdata, 1'b0};
                end else if (m0 && r.ctrl[ubrg_pkg::C_RXEN] &&
                             !r.stat[ubrg_pkg::S_RXD]) begin
                    n.sh_st = SH_M0RX;
                    n.sh = {3'h7, ubrg_pkg::CNT_TOP};
                end
            end
            SH_TX, SH_M0RX: begin
                if (m0) begin
                    n.sh_sub = r.sh_sub + 4'h1;
                    if (r.sh_sub == ubrg_pkg::M0_LAST) begin
                        n.sh_sub = 4'h0;
                        n.sh_bit = r.sh_bit + 4'h1;
                        n.sh = {3'h7, (r.sh_st == SH_M0RX) & rxd_in |
                            (r.sh_st == SH_TX), r.sh[7:1]};
                        if (r.sh_bit == sh_last) begin
                            n.sh_st = SH_IDLE;
                            if (r.sh_st == SH_M0RX) begin
                                n.rxdata = n.sh[7:0];
                                n.stat[ubrg_pkg::S_RXD] = 1'b1;
                            end else begin
                                n.stat[ubrg_pkg::S_TXD] = 1'b1;
                            end
                        end
                    end
                end else if (tick) begin
                    n.sh_sub = r.sh_sub + 4'h1;
                    if (r.sh_sub == ubrg_pkg::OVS_LAST) begin
                        n.sh = {1'b1, r.sh[10:1]};
                        n.sh_bit = r.sh_bit + 4'h1;
                        if (r.sh_bit == sh_last) begin
                            n.sh_st = SH_IDLE;
                            n.stat[ubrg_pkg::S_TXD] = 1'b1;
                        end
                    end
                end
            end
            default: n.sh_st = SH_IDLE;
        endcase
        // async receiver, independent of the transmitter
        unique case (r.rx_st)
            RX_IDLE: begin
                if (!m0 && r.ctrl[ubrg_pkg::C_RXEN] && tick &&
                    !rxd_in) begin
                    n.rx_st = RX_RUN;
                    n.rx_sub = 4'h0;
                    n.rx_bit = 4'h0;
                end
            end
            RX_RUN: begin
                if (tick) begin
                    n.rx_sub = r.rx_sub + 4'h1;
                    if (r.rx_sub == ubrg_pkg::OVS_LAST) begin
                        n.rx_bit = r.rx_bit + 4'h1;
                    end
                    if (r.rx_sub == ubrg_pkg::OVS_MID) begin
                        if (r.rx_bit == 4'h0) begin
                            if (rxd_in) begin
                                n.rx_st = RX_IDLE; // glitch, not a start
                            end
                        end else begin
                            n.rx_sh = rx_nsh;
                            if (r.rx_bit == rx_last) begin
                                n.rx_st = RX_IDLE;
                                if (rx_keep && n.stat[ubrg_pkg::S_RXD]) begin
                                    n.stat[ubrg_pkg::S_OVR] = 1'b1;
                                end else if (rx_keep) begin
                                    n.rxdata = rx_byte;
                                    n.stat[ubrg_pkg::S_RB9] = rx_b9;
                                    n.stat[ubrg_pkg::S_RXD] = 1'b1;
                                end
                            end
                        end
                    end
                end
                if (m0 || !r.ctrl[ubrg_pkg::C_RXEN]) begin
                    n.rx_st = RX_IDLE;
                end
            end
        endcase
        // divider overflow flag and request line, set wins over clear
        if (ndov) begin
            n.stat[ubrg_pkg::S_NDOV] = 1'b1;
        end
        n.irq = n.stat[ubrg_pkg::S_TXD] | n.stat[ubrg_pkg::S_RXD] |
            n.stat[ubrg_pkg::S_NDOV];
        // pin drive
        n.txd = (n.sh_st == SH_IDLE) ? ubrg_pkg::LINE_IDLE :
            (m0 ? n.sh_sub[0] : n.sh[0]);
        n.rxd_oe = m0 && n.sh_st == SH_TX;
        n.rxd_out = n.rxd_oe ? n.sh[0] : ubrg_pkg::LINE_IDLE;
    end

    // state register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
            r.txd <= ubrg_pkg::LINE_IDLE;
            r.rxd_out <= ubrg_pkg::LINE_IDLE;
        end else begin
            r <= n;
        end
    end

    // outputs straight from the state register
    assign rdata = r.rdata;
    assign txd = r.txd;
    assign rxd_out = r.rxd_out;
    assign rxd_oe = r.rxd_oe;
    assign irq_req = r.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    AST_OVR_KEEPS: assert property (
        $rose(r.stat[ubrg_pkg::S_OVR]) |-> r.rxdata == $past(r.rxdata))
        else $error("held byte overwritten on overrun");
    AST_LSB_FIRST: assert property (
        tx_go && !m0 |=> !txd && r.sh[1] == $past(bus.wdata[0]))
        else $error("start bit or first data bit wrong");
    AST_M0_CLOCK: assert property (
        (r.sh_st != SH_IDLE && m0) ##1 (r.sh_st != SH_IDLE && m0)
        |-> txd != $past(txd))
        else $error("mode 0 clock not at half rate");
    AST_M2_RATE: assert property (
        (m2_tick && !r.ctrl[ubrg_pkg::C_DBL]) ##1
        (!r.ctrl[ubrg_pkg::C_DBL])[*4] |-> m2_tick && !$past(m2_tick))
        else $error("mode 2 tick period wrong");
    AST_TX_IRQ: assert property (
        $rose(r.stat[ubrg_pkg::S_TXD]) |-> irq_req)
        else $error("no request at transmit end");
    AST_RX_START: assert property (
        r.rx_st == RX_IDLE && !m0 && r.ctrl[ubrg_pkg::C_RXEN] && tick &&
        !rxd_in |=> r.rx_st == RX_RUN && r.rx_sub == 4'h0)
        else $error("start edge not taken");

    COV_TX_DONE: cover property ($rose(r.stat[ubrg_pkg::S_TXD]));
    COV_RX_DONE: cover property ($rose(r.stat[ubrg_pkg::S_RXD]));
    COV_OVERRUN: cover property ($rose(r.stat[ubrg_pkg::S_OVR]));
    COV_NDOV: cover property ($rose(r.stat[ubrg_pkg::S_NDOV]));
endmodule // ubrg_uart
`default_nettype wire

//--- verification/uart_with_baud_rate_generator_bench.sv
`timescale 1ns/1ns
`default_nettype none
module uart_with_baud_rate_generator_bench;
    logic core_clk;
    logic reset_n;
    ubrg_pkg::ubrg_bus_t bus;
    logic [7:0] rdata;
    logic txd;
    logic rxd_in;
    logic rxd_out;
    logic rxd_oe;
    logic irq_req;
    int failures;
    int n_tests;
    logic [7:0] r;

    ubrg_uart ubrg_uart_i (.core_clk(core_clk), .reset_n(reset_n),
        .bus(bus), .rdata(rdata), .txd(txd), .rxd_in(rxd_in),
        .rxd_out(rxd_out), .rxd_oe(rxd_oe), .irq_req(irq_req));
    ubrg_remote_node ubrg_remote_node_i (.core_clk(core_clk), .txd(txd),
        .line(rxd_in));

    // 20 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // one-cycle strobes, a spare cycle keeps drivers apart
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        bus <= '0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        bus <= '0;
        #1;
        q = rdata;
        @(posedge core_clk);
    endtask

    // polls status until all bits of m are set, bounded
    task automatic wait_stat(input logic [7:0] m);
        int w;
        w = 0;
        r = 8'h00;
        while ((r & m) !== m) begin
            rd(ubrg_pkg::A_STAT, r);
            w++;
            if (w > 3000) begin
                failures++;
                results();
            end
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic duplex_mode2();
        for (int k = 0; k < 2; k++) begin
            ubrg_remote_node_i.bit_clks = k ? 64 : 32;
            wr(ubrg_pkg::A_CTRL, k ? 8'h26 : 8'h2E);
            fork
                wr(ubrg_pkg::A_TXBUF, 8'hA5);
                ubrg_remote_node_i.recv(9);
                ubrg_remote_node_i.send(9'h13C, 9);
            join
            wait_stat(8'h03);
            chk({7'h0, ubrg_remote_node_i.got}, 16'h01A5);
            chk({8'h0, r}, 16'h0007);
            chk({15'h0, irq_req}, 16'h0001);
            rd(ubrg_pkg::A_RXBUF, r);
            chk({8'h0, r}, 16'h003C);
            wr(ubrg_pkg::A_STAT, 8'h1F);
        end
    endtask

    // baud, divider, step, reload, clocks per bit
    task automatic baud_rates();
        logic [39:0] t [5];
        t = '{40'h03_00_00_00_20, 40'h05_00_00_01_80, 40'h01_00_00_03_40,
              40'h01_01_80_00_20, 40'h01_01_40_00_40};
        wr(ubrg_pkg::A_CTRL, 8'h05);
        for (int i = 0; i < 5; i++) begin
            wr(ubrg_pkg::A_BAUD, t[i][39:32]);
            wr(ubrg_pkg::A_FDIV, t[i][31:24]);
            wr(ubrg_pkg::A_STEP, t[i][23:16]);
            wr(ubrg_pkg::A_RELOAD, t[i][15:8]);
            ubrg_remote_node_i.bit_clks = int'(t[i][7:0]);
            fork
                wr(ubrg_pkg::A_TXBUF, 8'h3C);
                ubrg_remote_node_i.recv(8);
                ubrg_remote_node_i.send(9'h0C3, 8);
            join
            wait_stat(8'h03);
            chk({7'h0, ubrg_remote_node_i.got}, 16'h003C);
            rd(ubrg_pkg::A_RXBUF, r);
            chk({8'h0, r}, 16'h00C3);
            wr(ubrg_pkg::A_STAT, 8'h1F);
        end
    endtask

    task automatic overrun();
        ubrg_remote_node_i.send(9'h055, 8);
        ubrg_remote_node_i.send(9'h0AA, 8);
        rd(ubrg_pkg::A_STAT, r);
        chk({8'h0, r}, 16'h000E);
        rd(ubrg_pkg::A_RXBUF, r);
        chk({8'h0, r}, 16'h0055);
        wr(ubrg_pkg::A_STAT, 8'h1F);
    endtask

    // timer 1 paces mode 3, filter drops a frame with ninth bit low
    task automatic timer1_mode3();
        wr(ubrg_pkg::A_T1RLD, 8'hFF);
        wr(ubrg_pkg::A_CTRL, 8'h7F);
        repeat (520) @(posedge core_clk);
        ubrg_remote_node_i.bit_clks = 32;
        fork
            wr(ubrg_pkg::A_TXBUF, 8'h5A);
            ubrg_remote_node_i.recv(9);
            ubrg_remote_node_i.send(9'h012, 9);
        join
        chk({7'h0, ubrg_remote_node_i.got}, 16'h015A);
        ubrg_remote_node_i.send(9'h1C3, 9);
        wait_stat(8'h03);
        chk({8'h0, r}, 16'h0007);
        rd(ubrg_pkg::A_RXBUF, r);
        chk({8'h0, r}, 16'h00C3);
        wr(ubrg_pkg::A_STAT, 8'h1F);
    endtask

    task automatic shift_mode0();
        logic [7:0] b;
        logic [15:0] clk_pat;
        wr(ubrg_pkg::A_CTRL, 8'h00);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: ubrg_pkg::A_TXBUF, wdata: 8'h96};
        for (int i = 0; i < 16; i++) begin
            @(posedge core_clk);
            bus <= '0;
            #1;
            if (i % 2 == 0) b[i/2] = rxd_out & rxd_oe;
            clk_pat = {clk_pat[14:0], txd};
        end
        chk({8'h0, b}, 16'h0096);
        chk(clk_pat, 16'h5555);
        wait_stat(8'h01);
        // idle data line shifts in as all ones
        wr(ubrg_pkg::A_CTRL, 8'h04);
        wait_stat(8'h03);
        wr(ubrg_pkg::A_CTRL, 8'h00);
        rd(ubrg_pkg::A_RXBUF, r);
        chk({8'h0, r}, 16'h00FF);
        wr(ubrg_pkg::A_STAT, 8'h1F);
    endtask

    // normal divider mode halts the baud timer mid start bit
    task automatic normal_div();
        wr(ubrg_pkg::A_CTRL, 8'h05);
        wr(ubrg_pkg::A_STEP, 8'hFE);
        wr(ubrg_pkg::A_FDIV, 8'h03);
        wr(ubrg_pkg::A_TXBUF, 8'h00);
        repeat (300) @(posedge core_clk);
        chk({15'h0, txd}, 16'h0000);
        rd(ubrg_pkg::A_STAT, r);
        chk({8'h0, r}, 16'h0010);
        chk({15'h0, irq_req}, 16'h0001);
    endtask

    // reset, then the scenarios in turn
    initial begin
        reset_n = 1'b0;
        bus = '0;
        failures = 0;
        n_tests = 0;
        repeat (6) @(posedge core_clk);
        chk({4'h0, rdata, txd, rxd_out, rxd_oe, irq_req}, 16'h000C);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rd(4'hF, r);
        chk({8'h0, r}, 16'h0000);
        duplex_mode2();
        baud_rates();
        overrun();
        timer1_mode3();
        shift_mode0();
        normal_div();
        results();
    end
endmodule // uart_with_baud_rate_generator_bench
`default_nettype wire

//--- verification/ubrg_remote_node.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// remote serial node on the far side of the link
// ----------------------------------------
module ubrg_remote_node (
    input wire logic core_clk, // peripheral clock
    input wire logic txd, // line driven by the port
    output logic line // line into the port, pulled up when idle
);
    int bit_clks; // clocks per bit, set by the bench
    logic [8:0] got; // last frame heard, unknown on a bad frame

    // line rests high between frames
    initial begin
        bit_clks = 32;
        line = 1'b1;
    end

    // start low, data lsb first, stop high
    task automatic send(input logic [8:0] d, input int n);
        for (int k = 0; k < n + 2; k++) begin
            line <= (k == 0) ? 1'b0 : (k > n) ? 1'b1 : d[k-1];
            repeat (bit_clks) @(posedge core_clk);
        end
    endtask

    // waits for a start edge, then samples each bit at its middle
    task automatic recv(input int n);
        int w;
        w = 0;
        got = 'x;
        while (txd !== 1'b0 && w < 4000) begin
            @(posedge core_clk);
            w++;
        end
        if (w < 4000) begin
            got = '0;
            repeat (bit_clks / 2) @(posedge core_clk);
            for (int k = 1; k < n + 2; k++) begin
                repeat (bit_clks) @(posedge core_clk);
                if (k <= n) got[k-1] = txd;
                else if (txd !== 1'b1) got = 'x;
            end
        end
    endtask
endmodule // ubrg_remote_node
`default_nettype wire
